/* src/vdsc_top.sv */
// video dac input front end: sampling, demultiplexing, blanking and pulse insertion
`timescale 1ns/1ps
// What this block does
// - red/cr bus is ten bits, bit 0 lsb
// - sampled pulse insert forces pulse level first
// - pulse on luma only, or all channels
// - polarity bit picks pulse above or below blank
// - polarity ignored outside pulse insertion
// - two select bits choose one of four formats
// - 4:4:4 captures all buses every clock
// - 2x10 luma each clock, chroma half rate
// - 2x10 red bus alternates cb then cr
// - 1x10 luma bus carries cb y cr y
// - 1x10 luma every two, chroma every four
// - luma blanking code is zero
// - early variant chroma blank follows channel select
// - later variant chroma blank always mid code
// - sampled quiet level forces blanking level
// - format select a used unsampled, continuously
// - shared pin captured second edge after transition
module vdsc_top #(
  parameter int DATA_W = vdsc_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // pixel and control inputs
  input wire logic [DATA_W-1:0] red_cr_in_i,
  input wire logic [DATA_W-1:0] green_luma_in_i,
  input wire logic [DATA_W-1:0] blue_cb_in_i,
  input wire logic quiet_level_n_i,
  input wire logic pulse_insert_n_i,
  input wire logic pulse_polarity_hi_i,
  input wire logic format_sel_a_i,
  input wire logic format_sel_b_shared_i,
  // dac codes and pulse current controls
  output logic [DATA_W-1:0] red_cr_out_o,
  output logic [DATA_W-1:0] green_luma_out_o,
  output logic [DATA_W-1:0] blue_cb_out_o,
  output logic [2:0] pulse_on_o,
  output logic pulse_high_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [vdsc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam logic [DATA_W-1:0] BLK_ZERO = DATA_W'(vdsc_pkg::CODE_ZERO);
  localparam logic [DATA_W-1:0] BLK_MID = DATA_W'(vdsc_pkg::CODE_MID);

  // sampled inputs, first pipeline stage
  logic [DATA_W-1:0] red_s_r;
  logic [DATA_W-1:0] green_s_r;
  logic [DATA_W-1:0] blue_s_r;
  logic quiet_n_s_r;
  logic pulse_n_s_r;
  logic polarity_s_r;
  logic [1:0] phase_r;
  // mode state
  logic format_sel_b;
  logic pulse_on_all_channels;
  vdsc_pkg::vdsc_fmt_t fmt;
  // register state
  logic late_variant_r;
  logic force_quiet_r;
  logic [31:0] status;
  logic req;
  // output stage helpers
  logic quiet_act;
  logic pulse_act;
  logic [DATA_W-1:0] chroma_blank;

  // map the two select bits to a format
  function automatic vdsc_pkg::vdsc_fmt_t fmt_decode(input logic sel_a, input logic sel_b);
    vdsc_pkg::vdsc_fmt_t f;
    f = vdsc_pkg::VDSC_FMT_RGB444;
    case ({sel_a, sel_b})
      2'b00: f = vdsc_pkg::VDSC_FMT_RGB444;
      2'b01: f = vdsc_pkg::VDSC_FMT_YCC444;
      2'b10: f = vdsc_pkg::VDSC_FMT_422_2X;
      default: f = vdsc_pkg::VDSC_FMT_422_1X;
    endcase
    return f;
  endfunction

  // select a is read straight from the pin, select b from its capture
  assign fmt = fmt_decode(format_sel_a_i, format_sel_b);

  vdsc_mode_capture u_mode_capture (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .pulse_insert_n_s_i(pulse_n_s_r),
    .format_sel_b_shared_i(format_sel_b_shared_i),
    .format_sel_b_o(format_sel_b),
    .pulse_on_all_channels_o(pulse_on_all_channels)
  );

  // first stage: every bus and the quiet, pulse and polarity controls sampled on each rising edge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      red_s_r <= BLK_ZERO;
      green_s_r <= BLK_ZERO;
      blue_s_r <= BLK_ZERO;
      quiet_n_s_r <= 1'b0;
      pulse_n_s_r <= 1'b1;
      polarity_s_r <= 1'b0;
    end else begin
      red_s_r <= red_cr_in_i;
      green_s_r <= green_luma_in_i;
      blue_s_r <= blue_cb_in_i;
      quiet_n_s_r <= quiet_level_n_i;
      pulse_n_s_r <= pulse_insert_n_i;
      polarity_s_r <= pulse_polarity_hi_i;
    end
  end

  // phase of the sample held in the first stage; zero on the first after release
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= vdsc_pkg::PH_0;
    end else if (!quiet_level_n_i || !quiet_n_s_r) begin
      phase_r <= vdsc_pkg::PH_0;
    end else begin
      phase_r <= phase_r + vdsc_pkg::PH_STEP;
    end
  end

  // blanking and pulse decisions for the sample in the first stage
  assign quiet_act = !quiet_n_s_r || force_quiet_r;
  assign pulse_act = !pulse_n_s_r;
  assign chroma_blank = (late_variant_r || pulse_on_all_channels) ? BLK_MID : BLK_ZERO;

  // pulse current controls, aligned with the codes
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_on_o <= 3'b000;
      pulse_high_o <= 1'b0;
    end else begin
      pulse_on_o[1] <= pulse_act;
      pulse_on_o[0] <= pulse_act && pulse_on_all_channels;
      pulse_on_o[2] <= pulse_act && pulse_on_all_channels;
      pulse_high_o <= pulse_act && polarity_s_r;
    end
  end

  // luma path: blank level under pulse or quiet, else per format
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      green_luma_out_o <= BLK_ZERO;
    end else if (pulse_act || quiet_act) begin
      green_luma_out_o <= BLK_ZERO;
    end else begin
      case (fmt)
        vdsc_pkg::VDSC_FMT_422_1X: begin
          if (phase_r == vdsc_pkg::PH_1 || phase_r == vdsc_pkg::PH_3) begin
            green_luma_out_o <= green_s_r;
          end
        end
        default: begin
          green_luma_out_o <= green_s_r;
        end
      endcase
    end
  end

  // chroma paths: demultiplex per format
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      red_cr_out_o <= BLK_ZERO;
      blue_cb_out_o <= BLK_ZERO;
    end else if (pulse_act || quiet_act) begin
      red_cr_out_o <= chroma_blank;
      blue_cb_out_o <= chroma_blank;
    end else begin
      case (fmt)
        vdsc_pkg::VDSC_FMT_RGB444, vdsc_pkg::VDSC_FMT_YCC444: begin
          red_cr_out_o <= red_s_r;
          blue_cb_out_o <= blue_s_r;
        end
        vdsc_pkg::VDSC_FMT_422_2X: begin
          if (!phase_r[0]) begin
            blue_cb_out_o <= red_s_r;
          end else begin
            red_cr_out_o <= red_s_r;
          end
        end
        vdsc_pkg::VDSC_FMT_422_1X: begin
          if (phase_r == vdsc_pkg::PH_0) begin
            blue_cb_out_o <= green_s_r;
          end else if (phase_r == vdsc_pkg::PH_2) begin
            red_cr_out_o <= green_s_r;
          end
        end
        default: begin
          red_cr_out_o <= chroma_blank;
          blue_cb_out_o <= chroma_blank;
        end
      endcase
    end
  end

  // wishbone: one wait state, ack for one cycle per request
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // control register write
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      late_variant_r <= vdsc_pkg::CTRL_LATE_VARIANT_RST;
      force_quiet_r <= vdsc_pkg::CTRL_FORCE_QUIET_RST;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == vdsc_pkg::REG_CTRL) begin
      late_variant_r <= wb_dat_i[vdsc_pkg::CTRL_LATE_VARIANT_BIT];
      force_quiet_r <= wb_dat_i[vdsc_pkg::CTRL_FORCE_QUIET_BIT];
    end
  end

  // live status word
  always_comb begin
    status = 32'h0000_0000;
    status[vdsc_pkg::STAT_SEL_B_BIT] = format_sel_b;
    status[vdsc_pkg::STAT_SEL_A_BIT] = format_sel_a_i;
    status[vdsc_pkg::STAT_ALL_CH_BIT] = pulse_on_all_channels;
    status[vdsc_pkg::STAT_QUIET_BIT] = quiet_act;
    status[vdsc_pkg::STAT_PULSE_BIT] = pulse_act;
  end

  // read data, registered with the ack; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        vdsc_pkg::REG_CTRL: begin
          wb_dat_o <= 32'h0000_0000;
          wb_dat_o[vdsc_pkg::CTRL_LATE_VARIANT_BIT] <= late_variant_r;
          wb_dat_o[vdsc_pkg::CTRL_FORCE_QUIET_BIT] <= force_quiet_r;
        end
        vdsc_pkg::REG_STATUS: begin
          wb_dat_o <= status;
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule

/* common/vdsc_pkg.sv */
// shared constants and types of the video dac input sync controller
package vdsc_pkg;
  // width of each dac code path
  localparam int DATA_W = 10;
  // blanking codes
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MID = 10'h200;
  // register bus
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  // control register fields
  localparam int CTRL_LATE_VARIANT_BIT = 0;
  localparam int CTRL_FORCE_QUIET_BIT = 1;
  localparam logic CTRL_LATE_VARIANT_RST = 1'b0;
  localparam logic CTRL_FORCE_QUIET_RST = 1'b0;
  // status register fields
  localparam int STAT_SEL_B_BIT = 0;
  localparam int STAT_SEL_A_BIT = 1;
  localparam int STAT_ALL_CH_BIT = 2;
  localparam int STAT_QUIET_BIT = 3;
  localparam int STAT_PULSE_BIT = 4;
  // reset values of the captured mode bits
  localparam logic SEL_B_RST = 1'b0;
  localparam logic ALL_CH_RST = 1'b0;
  // demultiplexer phases
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam logic [1:0] PH_3 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;
  // input formats
  typedef enum logic [3:0] {
    VDSC_FMT_RGB444 = 4'b0001,
    VDSC_FMT_YCC444 = 4'b0010,
    VDSC_FMT_422_2X = 4'b0100,
    VDSC_FMT_422_1X = 4'b1000
  } vdsc_fmt_t;
endpackage

/* src/vdsc_mode_capture.sv */
// capture of the shared mode pin after each pulse insert transition
`timescale 1ns/1ps
module vdsc_mode_capture (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic pulse_insert_n_s_i,
  input wire logic format_sel_b_shared_i,
  output logic format_sel_b_o,
  output logic pulse_on_all_channels_o
);
  logic pulse_prev_r;
  logic edge_seen;

  // a difference between the sampled level and its copy marks the second edge
  assign edge_seen = pulse_insert_n_s_i ^ pulse_prev_r;

  // delayed copy of the sampled pulse insert level
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_prev_r <= 1'b1;
    end else begin
      pulse_prev_r <= pulse_insert_n_s_i;
    end
  end

  // rising transition stores the format bit, falling the channel select
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      format_sel_b_o <= vdsc_pkg::SEL_B_RST;
      pulse_on_all_channels_o <= vdsc_pkg::ALL_CH_RST;
    end else if (edge_seen) begin
      if (pulse_insert_n_s_i) begin
        format_sel_b_o <= format_sel_b_shared_i;
      end else begin
        pulse_on_all_channels_o <= format_sel_b_shared_i;
      end
    end
  end
endmodule

/* testbench/vdsc_chk.sv */
// port checker of the video dac front end, bound into its top
`timescale 1ns/1ps
module vdsc_chk #(
  parameter int DATA_W = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic quiet_level_n_i,
  input wire logic pulse_insert_n_i,
  input wire logic pulse_polarity_hi_i,
  input wire logic [DATA_W-1:0] red_cr_out_o,
  input wire logic [DATA_W-1:0] green_luma_out_o,
  input wire logic [DATA_W-1:0] blue_cb_out_o,
  input wire logic [2:0] pulse_on_o,
  input wire logic pulse_high_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // controls sampled two edges back decide each output
  sequence s_blank;
    !$past(quiet_level_n_i, 2) && $past(pulse_insert_n_i, 2);
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_pulse_luma;
    !$past(pulse_insert_n_i, 2) |-> pulse_on_o[1] && green_luma_out_o == '0;
  endproperty
  a_pulse_luma: assert property (p_pulse_luma) else $error("no luma pulse");
  property p_pulse_pol;
    !$past(pulse_insert_n_i, 2) |-> pulse_high_o == $past(pulse_polarity_hi_i, 2);
  endproperty
  a_pulse_pol: assert property (p_pulse_pol) else $error("pulse polarity wrong");
  property p_no_pulse;
    $past(pulse_insert_n_i, 2) |-> pulse_on_o == 3'b000 && !pulse_high_o;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulse outside interval");
  property p_channels;
    |pulse_on_o |-> pulse_on_o[1] && pulse_on_o[0] == pulse_on_o[2];
  endproperty
  a_channels: assert property (p_channels) else $error("pulse channel set wrong");
  property p_quiet;
    s_blank |-> green_luma_out_o == '0 && red_cr_out_o == blue_cb_out_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("blanking not applied");
  property p_blank_code;
    s_blank |-> red_cr_out_o == '0 || red_cr_out_o == vdsc_pkg::CODE_MID;
  endproperty
  a_blank_code: assert property (p_blank_code) else $error("chroma blank code wrong");
  property p_ack_rise;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("bus answer late");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus answer too long");
endmodule
bind vdsc_top vdsc_chk #(.DATA_W(DATA_W)) i_vdsc_chk (.*);

/* testbench/vdsc_src_model.sv */
// video source model driving the pixel and control pins
`timescale 1ns/1ps
module vdsc_src_model (
  input wire logic clk_sys_i,
  output logic [9:0] red_cr_o = 10'h000,
  output logic [9:0] green_luma_o = 10'h000,
  output logic [9:0] blue_cb_o = 10'h000,
  output logic quiet_level_n_o = 1'b0,
  output logic pulse_insert_n_o = 1'b1,
  output logic pulse_polarity_hi_o = 1'b0,
  output logic format_sel_b_shared_o = 1'b0
);
  // one pixel per clock with its blanking control
  task automatic put(input logic [9:0] r, g, b, input logic q);
    @(posedge clk_sys_i);
    red_cr_o <= r;
    green_luma_o <= g;
    blue_cb_o <= b;
    quiet_level_n_o <= q;
  endtask
  // pulse of n clocks; shared pin is wrong on the first edge that sees a change
  task automatic sync(input int n, input logic tri_lvl, input logic all_ch, input logic sel_b);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clk_sys_i);
      pulse_insert_n_o <= (i >= n);
      pulse_polarity_hi_o <= tri_lvl && i >= n / 2 && i <= n;
      format_sel_b_shared_o <= (i < n) ? all_ch ^ (i == 0) : sel_b ^ (i == n);
    end
  endtask
endmodule

/* testbench/video_dac_input_sync_ctrl_tb.sv */
// self-checking bench of the video dac front end
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
module video_dac_input_sync_ctrl_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic format_sel_a_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [9:0] red_cr_in_i, green_luma_in_i, blue_cb_in_i;
  logic [9:0] red_cr_out_o, green_luma_out_o, blue_cb_out_o;
  logic quiet_level_n_i, pulse_insert_n_i, pulse_polarity_hi_i, format_sel_b_shared_i;
  logic pulse_high_o, wb_ack_o;
  logic [2:0] pulse_on_o;
  logic [31:0] wb_dat_o, rd;
  int mismatches = 0;
  int n_tests = 0;
  wire [29:0] outs = {red_cr_out_o, green_luma_out_o, blue_cb_out_o};
  always #2.5 clk_sys_i = ~clk_sys_i;
  vdsc_src_model i_vdsc_src_model (.clk_sys_i(clk_sys_i), .red_cr_o(red_cr_in_i),
    .green_luma_o(green_luma_in_i), .blue_cb_o(blue_cb_in_i), .quiet_level_n_o(quiet_level_n_i),
    .pulse_insert_n_o(pulse_insert_n_i), .pulse_polarity_hi_o(pulse_polarity_hi_i),
    .format_sel_b_shared_o(format_sel_b_shared_i));
  vdsc_top i_vdsc_top (.*);
  // distinct code per sample and lane
  function automatic logic [9:0] px(input int k, input int lane);
    return 10'(k * 67 + lane * 300 + 5);
  endfunction
  // one classic bus cycle; waits on ack, only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // full rate: buses straight through, then blank
  task automatic t_full();
    for (int k = 0; k < 10; k++) begin
      i_vdsc_src_model.put(px(k, 0), px(k, 1), px(k, 2), k < 6);
      #1;
      if (k >= 2 && k < 8) `CHK(outs, {px(k - 2, 0), px(k - 2, 1), px(k - 2, 2)})
    end
    `CHK(outs, 30'h0000_0000)
    $display("test full rate done");
  endtask
  // two lanes: luma every clock, red lane cb then cr
  task automatic t_dual();
    @(posedge clk_sys_i);
    format_sel_a_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      i_vdsc_src_model.put(px(k, 0), px(k, 1), px(k, 2), 1'b1);
      #1;
      if (k >= 2) `CHK(green_luma_out_o, px(k - 2, 1))
      if (k >= 2) `CHK(k % 2 ? red_cr_out_o : blue_cb_out_o, px(k - 2, 0))
    end
    $display("test dual lane done");
  endtask
  // luma only until the shared pin is taken, then all channels
  task automatic t_sync();
    fork
      i_vdsc_src_model.sync(4, 1'b1, 1'b1, 1'b1);
      begin
        repeat (3) @(posedge clk_sys_i);
        #1;
        `CHK({pulse_on_o, pulse_high_o, green_luma_out_o}, 14'h1000)
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK({pulse_on_o, pulse_high_o, green_luma_out_o}, 14'h3c00)
        `CHK(red_cr_out_o, 10'h200)
      end
    join
    $display("test sync done");
  endtask
  // one lane: luma bus carries cb, y, cr, y
  task automatic t_single();
    i_vdsc_src_model.put(10'h000, 10'h000, 10'h000, 1'b0);
    for (int k = 0; k < 10; k++) begin
      i_vdsc_src_model.put(px(k, 2), px(k, 1), px(k, 0), 1'b1);
      #1;
      if (k >= 2) begin
        case ((k - 2) % 4)
          0: `CHK(blue_cb_out_o, px(k - 2, 1))
          2: `CHK(red_cr_out_o, px(k - 2, 1))
          default: `CHK(green_luma_out_o, px(k - 2, 1))
        endcase
      end
    end
    $display("test single lane done");
  endtask
  // registers, unmapped read, blank code of each variant
  task automatic t_regs();
    i_vdsc_src_model.sync(2, 1'b0, 1'b0, 1'b1);
    repeat (3) i_vdsc_src_model.put(10'h155, 10'h0aa, 10'h3ff, 1'b0);
    #1;
    `CHK(outs, 30'h0000_0000)
    wb(1'b1, vdsc_pkg::REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK(outs, {vdsc_pkg::CODE_MID, vdsc_pkg::CODE_ZERO, vdsc_pkg::CODE_MID})
    wb(1'b0, vdsc_pkg::REG_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    wb(1'b0, vdsc_pkg::REG_STATUS, 32'h0000_0000);
    `CHK(rd[2:0], 3'b011)
    wb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("test registers done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    `CHK(outs, 30'h0000_0000)
    t_full();
    t_dual();
    t_sync();
    t_single();
    t_regs();
    conclude();
  end
  // watchdog, far beyond the few dozen clocks needed
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
